/* design/cbcg_gate.sv */
// Configuration cycle gate for a directly attached card bus card
`timescale 1ns/100ps
module cbcg_gate
    import cbcg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic host_frame_n,
    input wire logic host_irdy_n,
    input wire logic [CBCG_CBE_W-1:0] host_cbe_n,
    input wire logic [CBCG_AD_W-1:0] card_addr_data_bus,
    input wire logic cfg_arm,
    input wire logic cfg_for_card,
    input wire logic host_shared_irq_n,
    input wire logic card_is_master,
    output logic init_device_select,
    output logic cfg_armed,
    output logic cfg_seen,
    output logic cfg_passed,
    output logic cfg_misrouted,
    output logic [CBCG_FUNC_W-1:0] cfg_func,
    output logic [CBCG_WORD_W-1:0] cfg_word,
    output logic irq_active,
    output logic card_type_master,
    output logic arb_slot_en,
    output logic clock_run_request_n_o,
    output logic clock_run_request_n_oe
);
    // ==========================================================
    // Declarations
    cbcg_state_t state_ff, nxt_state;
    logic gate_ff, nxt_gate;
    logic target_card_ff, nxt_target_card;
    logic frame_prev_ff;
    logic seen_ff, nxt_seen;
    logic passed_ff, nxt_passed;
    logic mis_ff, nxt_mis;
    logic [CBCG_FUNC_W-1:0] func_ff, nxt_func;
    logic [CBCG_WORD_W-1:0] word_ff, nxt_word;
    logic irq_ff;
    logic type_ff, nxt_type;
    logic type_done_ff;
    logic addr_phase;
    logic is_cfg;
    logic [CBCG_FUNC_W-1:0] dec_func;
    logic [CBCG_WORD_W-1:0] dec_word;
    logic bus_idle;
    logic armed_ff, nxt_armed;

    // ==========================================================
    // Address phase decode
    cbcg_addr_decode u_dec (
        .frame_n_prev(frame_prev_ff),
        .frame_n(host_frame_n),
        .cbe_n(host_cbe_n),
        .ad(card_addr_data_bus),
        .addr_phase(addr_phase),
        .is_cfg(is_cfg),
        .func(dec_func),
        .word(dec_word)
    );

    // Bus is idle with frame and initiator ready both released
    assign bus_idle = host_frame_n & host_irdy_n;

    // ==========================================================
    // Gate sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_gate = gate_ff;
        nxt_target_card = target_card_ff;
        nxt_seen = 1'h0;
        nxt_passed = 1'h0;
        nxt_mis = 1'h0;
        nxt_func = func_ff;
        nxt_word = word_ff;
        if (addr_phase && is_cfg) begin
            nxt_seen = 1'h1;
            nxt_func = dec_func;
            nxt_word = dec_word;
            nxt_passed = (gate_ff == CBCG_GATE_PASS);
        end
        case (state_ff)
            CBCG_ST_IDLE: begin
                if (cfg_arm) begin
                    nxt_target_card = cfg_for_card;
                    nxt_state = CBCG_ST_WAIT;
                end
                // Unannounced configuration cycle still reaches the card
                if (addr_phase && is_cfg) begin
                    nxt_mis = 1'h1;
                end
            end
            CBCG_ST_WAIT: begin
                if (bus_idle) begin
                    nxt_gate = target_card_ff ? CBCG_GATE_PASS : CBCG_GATE_BLOCK;
                    nxt_state = CBCG_ST_ARMED;
                end
            end
            CBCG_ST_ARMED: begin
                if (addr_phase) begin
                    nxt_state = CBCG_ST_BUSY;
                    if (!is_cfg) begin
                        nxt_mis = 1'h1;
                    end
                end
            end
            CBCG_ST_BUSY: begin
                if (bus_idle) begin
                    nxt_gate = CBCG_GATE_PASS;
                    nxt_state = CBCG_ST_IDLE;
                end
            end
            default: begin
                nxt_gate = CBCG_GATE_PASS;
                nxt_state = CBCG_ST_IDLE;
            end
        endcase
        // Armed flag registered so the output comes from a flop
        nxt_armed = (nxt_state == CBCG_ST_ARMED);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= CBCG_ST_IDLE;
            gate_ff <= CBCG_GATE_PASS;
            target_card_ff <= 1'h0;
            seen_ff <= 1'h0;
            passed_ff <= 1'h0;
            mis_ff <= 1'h0;
            armed_ff <= 1'h0;
            func_ff <= '0;
            word_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            gate_ff <= nxt_gate;
            target_card_ff <= nxt_target_card;
            seen_ff <= nxt_seen;
            passed_ff <= nxt_passed;
            mis_ff <= nxt_mis;
            armed_ff <= nxt_armed;
            func_ff <= nxt_func;
            word_ff <= nxt_word;
        end
    end

    // ==========================================================
    // Frame history and shared interrupt sampling
    always_ff @(posedge clk) begin
        if (rst) begin
            frame_prev_ff <= 1'h1;
            irq_ff <= 1'h0;
        end else begin
            frame_prev_ff <= host_frame_n;
            irq_ff <= ~host_shared_irq_n;
        end
    end

    // ==========================================================
    // Card type captured once after reset release
    always_comb begin
        nxt_type = type_done_ff ? type_ff : card_is_master;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            type_ff <= 1'h0;
            type_done_ff <= 1'h0;
        end else begin
            type_ff <= nxt_type;
            type_done_ff <= 1'h1;
        end
    end

    // ==========================================================
    // Outputs
    assign init_device_select = gate_ff;
    assign cfg_armed = armed_ff;
    assign cfg_seen = seen_ff;
    assign cfg_passed = passed_ff;
    assign cfg_misrouted = mis_ff;
    assign cfg_func = func_ff;
    assign cfg_word = word_ff;
    assign irq_active = irq_ff;
    assign card_type_master = type_ff;
    assign arb_slot_en = type_ff;
    assign clock_run_request_n_o = CBCG_CLKRUN_LEVEL;
    assign clock_run_request_n_oe = type_done_ff | ~type_done_ff;
endmodule

/* shared/cbcg_pkg.sv */
// Constants and types for the card bus configuration cycle gate
package cbcg_pkg;
    // ==========================================================
    // Bus field layout
    localparam int CBCG_AD_W = 32;
    localparam int CBCG_CBE_W = 4;
    localparam int CBCG_FUNC_HI = 10;
    localparam int CBCG_FUNC_LO = 8;
    localparam int CBCG_WORD_HI = 7;
    localparam int CBCG_WORD_LO = 2;
    localparam int CBCG_FUNC_W = CBCG_FUNC_HI - CBCG_FUNC_LO + 1;
    localparam int CBCG_WORD_W = CBCG_WORD_HI - CBCG_WORD_LO + 1;
    // ==========================================================
    // Bus commands
    localparam logic [CBCG_CBE_W-1:0] CBCG_CMD_CFG_RD = 4'hA;
    localparam logic [CBCG_CBE_W-1:0] CBCG_CMD_CFG_WR = 4'hB;
    // ==========================================================
    // Reset and fixed levels
    localparam logic CBCG_GATE_PASS = 1'h0;
    localparam logic CBCG_GATE_BLOCK = 1'h1;
    localparam logic CBCG_CLKRUN_LEVEL = 1'h0;
    // ==========================================================
    // Gate sequencer states
    typedef enum logic [3:0] {
        CBCG_ST_IDLE = 4'h1,
        CBCG_ST_WAIT = 4'h2,
        CBCG_ST_ARMED = 4'h4,
        CBCG_ST_BUSY = 4'h8
    } cbcg_state_t;
endpackage

/* design/cbcg_addr_decode.sv */
// Address phase decoder for configuration cycles
`timescale 1ns/100ps
module cbcg_addr_decode
    import cbcg_pkg::*;
(
    input wire logic frame_n_prev,
    input wire logic frame_n,
    input wire logic [CBCG_CBE_W-1:0] cbe_n,
    input wire logic [CBCG_AD_W-1:0] ad,
    output logic addr_phase,
    output logic is_cfg,
    output logic [CBCG_FUNC_W-1:0] func,
    output logic [CBCG_WORD_W-1:0] word
);
    // ==========================================================
    // Start of transaction and field split
    always_comb begin
        addr_phase = frame_n_prev & ~frame_n;
        is_cfg = (cbe_n == CBCG_CMD_CFG_RD) || (cbe_n == CBCG_CMD_CFG_WR);
        func = ad[CBCG_FUNC_HI:CBCG_FUNC_LO];
        word = ad[CBCG_WORD_HI:CBCG_WORD_LO];
    end
endmodule

/* test/cbcg_monitor.sv */
// Checker for the configuration cycle gate
`timescale 1ns/100ps
module cbcg_monitor
    import cbcg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic host_frame_n,
    input wire logic host_irdy_n,
    input wire logic [CBCG_CBE_W-1:0] host_cbe_n,
    input wire logic [CBCG_AD_W-1:0] card_addr_data_bus,
    input wire logic host_shared_irq_n,
    input wire logic init_device_select,
    input wire logic cfg_seen,
    input wire logic cfg_passed,
    input wire logic cfg_misrouted,
    input wire logic [CBCG_FUNC_W-1:0] cfg_func,
    input wire logic [CBCG_WORD_W-1:0] cfg_word,
    input wire logic irq_active,
    input wire logic card_type_master,
    input wire logic arb_slot_en,
    input wire logic clock_run_request_n_o,
    input wire logic clock_run_request_n_oe
);
    // ==========
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence cfg_ap;
        $past(host_frame_n) && !host_frame_n && host_cbe_n[3:1] == 3'h5;
    endsequence
    a_gate_when_idle: assert property ($changed(init_device_select) |->
        $past(host_frame_n) && $past(host_irdy_n)) else $error("gate moved mid cycle");
    a_pass_flag: assert property (cfg_seen |-> cfg_passed == !$past(init_device_select))
        else $error("pass flag wrong");
    a_cfg_seen: assert property (cfg_ap |=> cfg_seen) else $error("cfg cycle missed");
    a_cfg_fields: assert property (cfg_ap |=> cfg_func == $past(card_addr_data_bus[10:8])
        && cfg_word == $past(card_addr_data_bus[7:2])) else $error("fields wrong");
    a_seen_pulse: assert property (cfg_seen |=> !cfg_seen) else $error("seen too long");
    a_clkrun_low: assert property (!clock_run_request_n_o && clock_run_request_n_oe)
        else $error("clock run not low");
    a_arb_slot: assert property (arb_slot_en == card_type_master)
        else $error("arbiter slot wrong");
    a_irq_follow: assert property (!$past(rst) |-> irq_active == !$past(host_shared_irq_n))
        else $error("irq not followed");
    c_pass: cover property (cfg_seen && cfg_passed);
    c_block: cover property (cfg_seen && !cfg_passed);
    c_misr: cover property (cfg_misrouted);
endmodule

/* test/cbcg_card_model.sv */
// Card side model: counts frames it sees, drives its interrupt
`timescale 1ns/100ps
module cbcg_card_model (
    input wire logic clk,
    input wire logic card_frame_n,
    input wire logic irq_req,
    output logic card_irq_oe,
    output int frames
);
    logic prev = 1'h1;
    initial frames = 0;
    assign card_irq_oe = irq_req;
    always @(posedge clk) begin
        prev <= card_frame_n;
        if (prev && !card_frame_n) frames <= frames + 1;
    end
endmodule

/* test/testbench.sv */
// Self-checking bench for the gate
`timescale 1ns/100ps
`define chk(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
    $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module testbench
    import cbcg_pkg::*;
;
    logic clk = 0, rst = 1, host_frame_n = 1, host_irdy_n = 1, cfg_arm = 0, cfg_for_card = 0;
    logic card_is_master = 0, irq_req = 0, misr_q = 0;
    logic [3:0] host_cbe_n = 4'h0;
    logic [31:0] card_addr_data_bus = 32'h0;
    logic init_device_select, cfg_armed, cfg_seen, cfg_passed, cfg_misrouted, irq_active;
    logic card_type_master, arb_slot_en, clock_run_request_n_o, clock_run_request_n_oe;
    logic [2:0] cfg_func;
    logic [5:0] cfg_word;
    int err_total = 0, checks_done = 0, frames;
    wire irq_oe;
    wire host_shared_irq_n = irq_oe ? 1'h0 : 1'h1;
    cbcg_gate u_dut(.clk(clk), .rst(rst), .host_frame_n(host_frame_n), .host_irdy_n(host_irdy_n),
        .host_cbe_n(host_cbe_n), .card_addr_data_bus(card_addr_data_bus), .cfg_arm(cfg_arm),
        .cfg_for_card(cfg_for_card), .host_shared_irq_n(host_shared_irq_n),
        .card_is_master(card_is_master), .init_device_select(init_device_select),
        .cfg_armed(cfg_armed), .cfg_seen(cfg_seen), .cfg_passed(cfg_passed),
        .cfg_misrouted(cfg_misrouted), .cfg_func(cfg_func), .cfg_word(cfg_word),
        .irq_active(irq_active), .card_type_master(card_type_master), .arb_slot_en(arb_slot_en),
        .clock_run_request_n_o(clock_run_request_n_o),
        .clock_run_request_n_oe(clock_run_request_n_oe));
    cbcg_card_model u_card(.clk(clk), .card_frame_n(host_frame_n | init_device_select),
        .irq_req(irq_req), .card_irq_oe(irq_oe), .frames(frames));
    initial forever #20 clk = ~clk;
    always @(posedge clk) if (cfg_misrouted) misr_q <= 1'h1;
    // ==========
    // Tasks
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic await(input bit low);
        int i;
        for (i = 0; i < 20 && (low ? init_device_select !== 0 : cfg_armed !== 1); i++) begin
            @(negedge clk);
        end
        if (i == 20) begin
            err_total++;
            report_and_stop();
        end
    endtask
    function automatic bit exp_cfg(input logic [3:0] cmd);
        return cmd[3:1] == 3'h5;
    endfunction
    function automatic bit exp_pass(input bit arm, input bit tgt);
        return !arm || tgt;
    endfunction
    task automatic run(input bit arm, tgt, input logic [3:0] cmd);
        int f0;
        bit is_cfg;
        bit pass;
        is_cfg = exp_cfg(cmd);
        pass = exp_pass(arm, tgt);
        f0 = frames;
        misr_q = 0;
        cfg_for_card = tgt;
        cfg_arm = arm;
        @(negedge clk);
        cfg_arm = 0;
        if (arm) begin
            await(0);
            `chk(init_device_select, !tgt)
        end
        host_cbe_n = cmd;
        card_addr_data_bus = $urandom;
        host_frame_n = 0;
        @(negedge clk);
        host_frame_n = 1;
        host_irdy_n = 0;
        `chk(cfg_seen, is_cfg)
        if (is_cfg) begin
            `chk(cfg_passed, pass)
            `chk({cfg_func, cfg_word}, card_addr_data_bus[10:2])
        end
        @(negedge clk);
        host_irdy_n = 1;
        await(1);
        repeat (2) @(negedge clk);
        `chk(frames - f0 == 1, pass)
        `chk(misr_q, arm != is_cfg)
        irq_req = 1'($urandom);
        repeat (2) @(negedge clk);
        `chk(irq_active, irq_req)
    endtask
    // ==========
    // Sequence
    initial begin
        void'($urandom(32'h233C));
        card_is_master = 1'($urandom);
        repeat (16) @(negedge clk);
        rst = 0;
        repeat (2) @(negedge clk);
        `chk({card_type_master, arb_slot_en}, {2{card_is_master}})
        `chk({clock_run_request_n_o, clock_run_request_n_oe}, 2'h1)
        run(1, 1, CBCG_CMD_CFG_RD);
        run(1, 0, CBCG_CMD_CFG_WR);
        run(0, 0, CBCG_CMD_CFG_RD);
        run(1, 0, 4'h6);
        repeat (40) run(1'($urandom), 1'($urandom), {$urandom_range(1) ? 3'h5 : 3'h3, 1'($urandom)});
        report_and_stop();
    end
endmodule
bind cbcg_gate cbcg_monitor u_mon(.clk(clk), .rst(rst), .host_frame_n(host_frame_n),
    .host_irdy_n(host_irdy_n), .host_cbe_n(host_cbe_n), .card_addr_data_bus(card_addr_data_bus),
    .host_shared_irq_n(host_shared_irq_n), .init_device_select(init_device_select),
    .cfg_seen(cfg_seen), .cfg_passed(cfg_passed), .cfg_misrouted(cfg_misrouted),
    .cfg_func(cfg_func), .cfg_word(cfg_word), .irq_active(irq_active),
    .card_type_master(card_type_master), .arb_slot_en(arb_slot_en),
    .clock_run_request_n_o(clock_run_request_n_o),
    .clock_run_request_n_oe(clock_run_request_n_oe));
